//--- src/dss_defines.svh
// Register offsets, field positions, reset values and timing counts of the step sequencer.
`ifndef DSS_DEFINES_SVH
`define DSS_DEFINES_SVH

`define DSS_REG_DIV_MODE      8'h02
`define DSS_REG_CHOP_CFG      8'h03
`define DSS_REG_CTRL_A        8'h00
`define DSS_REG_CTRL_B        8'h01
`define DSS_DIV_A_LSB         0
`define DSS_DIV_B_LSB         2
`define DSS_MODE_A_LSB        4
`define DSS_MODE_B_LSB        6
`define DSS_CHOP_LSB          0
`define DSS_SENSOR_BIT        2
`define DSS_FLAG_PAIR_BIT     3
`define DSS_FLAG_HALF_BIT     4
`define DSS_CTRL_CNT_RESET_BIT 6
`define DSS_CTRL_OUT_EN_BIT   7
`define DSS_REG_RESET         8'h00
`define DSS_CTRL_RESET        8'h40
`define DSS_CLK_HZ            50000000
`define DSS_CHOP_400K_HZ      400000
`define DSS_CHOP_200K_HZ      200000
`define DSS_CHOP_600K_HZ      600000
`define DSS_CHOP_300K_HZ      300000
`define DSS_POS_INIT          8'h00
`define DSS_POS_COUNT         9'h100
`define DSS_HALF_STEP_SPAN    8'h20
`define DSS_FULL_STEP_OFFSET  8'h20

`endif

//--- src/dss_pkg.sv
// Types shared by the step sequencer modules.
package dss_pkg;
    typedef enum logic [1:0] {
        DSS_MICRO,
        DSS_HALF,
        DSS_HALF_FT,
        DSS_FULL
    } dss_mode_e;

    typedef logic [7:0] dss_pos_t;
endpackage

//--- src/dss_step_if.sv
// Connection between the top and one channel-pair step engine.
`timescale 1ns/1ps
`default_nettype none
interface dss_step_if;
    logic              step_sync;
    logic              chip_active;
    logic              counter_reset;
    logic [1:0]        div_code;
    dss_pkg::dss_mode_e mode;
    dss_pkg::dss_pos_t position;
    logic              at_initial;
    logic              at_half;

    modport top (
        output step_sync,
        output chip_active,
        output counter_reset,
        output div_code,
        output mode,
        input  position,
        input  at_initial,
        input  at_half
    );
    modport engine (
        input  step_sync,
        input  chip_active,
        input  counter_reset,
        input  div_code,
        input  mode,
        output position,
        output at_initial,
        output at_half
    );
endinterface
`default_nettype wire

//--- src/dss_step_engine.sv
// Step clock divider and excitation position counter for one channel pair.
`timescale 1ns/1ps
`default_nettype none
`include "dss_defines.svh"
module dss_step_engine (
    input  wire logic     clk,
    input  wire logic     reset_n,
    dss_step_if.engine    sif
);
    typedef struct packed {
        logic              prev_step;
        logic [2:0]        div_cnt;
        dss_pkg::dss_pos_t pos;
    } dss_eng_s;

    dss_eng_s st;
    dss_eng_s next_st;

    function automatic logic [2:0] dss_div_last(input logic [1:0] code);
        dss_div_last = 3'((4'h1 << code) - 4'h1);
    endfunction

    function automatic dss_pkg::dss_pos_t dss_step_size(input dss_pkg::dss_mode_e m);
        case (m)
            dss_pkg::DSS_MICRO: dss_step_size = 8'h01;
            dss_pkg::DSS_FULL:  dss_step_size = 8'h40;
            default:            dss_step_size = 8'h20;
        endcase
    endfunction

    always_comb begin
        next_st = st;
        next_st.prev_step = sif.step_sync;
        if (!sif.chip_active || sif.counter_reset) begin
            next_st.div_cnt = 3'h0;
            next_st.pos     = `DSS_POS_INIT;
        end else if (sif.step_sync && !st.prev_step) begin
            if (st.div_cnt >= dss_div_last(sif.div_code)) begin
                next_st.div_cnt = 3'h0;
                // Mode is sampled here, so a new mode takes effect on the next step.
                if (sif.mode != dss_pkg::DSS_MICRO &&
                    (st.pos % dss_step_size(sif.mode)) != 8'h00) begin
                    next_st.pos = st.pos - (st.pos % dss_step_size(sif.mode))
                                  + dss_step_size(sif.mode);
                end else begin
                    next_st.pos = st.pos + dss_step_size(sif.mode);
                end
            end else begin
                next_st.div_cnt = st.div_cnt + 3'h1;
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // Full step sits a half step off the micro grid, so initial there means offset -100%.
    assign sif.position   = (sif.mode == dss_pkg::DSS_FULL) ? st.pos - `DSS_FULL_STEP_OFFSET
                                                            : st.pos;
    assign sif.at_initial = (st.pos == `DSS_POS_INIT);
    assign sif.at_half    = (st.pos % `DSS_HALF_STEP_SPAN) == 8'h00;
endmodule
`default_nettype wire

//--- src/dss_sequencer.sv
// Top of the dual stepper step sequencer: registers, pin sync, gating and flag.
//
// What this block does
// - Divide each pair's step clock by 1, 2, 4 or 8 from register two.
// - Register two bits 5:4 and 7:6 select each pair's excitation mode.
// - Register three bits 1:0 pick chopping 400, 200, 600 or 300 kHz.
// - Register three bit two turns the photo-sensor drive off or on.
// - Register three bit three selects which pair drives the flag pin.
// - Register three bit four selects initial or half step flag position.
// - Outputs drive only when chip-active is high and output enable is on.
// - Configuration writes are stored even while chip-active is low.
// - Power-up reset clears registers two and three, loads 40h into both control registers and forces output enable off.
// - Steps advance on step clock rising edges only while chip-active is high.
// - Position returns to initial at reset and on counter reset.
// - Initial currents are 100% and 0%, or 100% and -100% in full step.
// - Flag pin goes low at the selected position of the selected pair.
// - Half step flag selection acts as initial outside micro-step mode.
// - Flag stays low from the reaching edge until the leaving edge.
// - A new mode is latched on the write and used from the next step.
// - Output enable changes on the write; position keeps advancing while off.
// - Chip-active low parks both pairs at the initial position.
`timescale 1ns/1ps
`default_nettype none
`include "dss_defines.svh"
module dss_sequencer #(
    parameter int CLK_HZ = `DSS_CLK_HZ
) (
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic        chip_active_pin,
    input  wire logic        step_clock_pair_a,
    input  wire logic        step_clock_pair_b,
    input  wire logic        cfg_write,
    input  wire logic [7:0]  cfg_addr,
    input  wire logic [7:0]  cfg_data,
    output logic [7:0]       cfg_rdata,
    output logic [7:0]       position_pair_a,
    output logic [7:0]       position_pair_b,
    output logic             full_step_pair_a,
    output logic             full_step_pair_b,
    output logic             motor_out_en_n,
    output logic             chop_tick,
    output logic             sensor_drive,
    output logic             position_flag_pin
);
    typedef struct packed {
        logic [1:0]  act_sync;
        logic [1:0]  stepa_sync;
        logic [1:0]  stepb_sync;
        logic [7:0]  div_mode;
        logic [7:0]  chop_cfg;
        logic [7:0]  ctrl_a;
        logic [7:0]  ctrl_b;
        logic [15:0] chop_cnt;
        logic        chop_tick;
        logic [7:0]  rdata;
        logic [7:0]  pos_a;
        logic [7:0]  pos_b;
        logic        full_a;
        logic        full_b;
        logic        out_en_n;
        logic        flag;
    } dss_top_s;

    dss_top_s st;
    dss_top_s next_st;

    dss_step_if sif_a ();
    dss_step_if sif_b ();

    function automatic logic [15:0] dss_chop_period(input logic [1:0] code);
        case (code)
            2'h0:    dss_chop_period = 16'(CLK_HZ / `DSS_CHOP_400K_HZ);
            2'h1:    dss_chop_period = 16'(CLK_HZ / `DSS_CHOP_200K_HZ);
            2'h2:    dss_chop_period = 16'(CLK_HZ / `DSS_CHOP_600K_HZ);
            default: dss_chop_period = 16'(CLK_HZ / `DSS_CHOP_300K_HZ);
        endcase
    endfunction

    function automatic logic dss_flag_hit(input logic half_sel, input dss_pkg::dss_mode_e m,
                                          input logic at_init, input logic at_half);
        // Half-step marking only means something in micro-step mode.
        if (half_sel && m == dss_pkg::DSS_MICRO) begin
            dss_flag_hit = at_half;
        end else begin
            dss_flag_hit = at_init;
        end
    endfunction

    // Step clocks and chip-active are pins; only the second stage feeds logic.
    assign sif_a.step_sync     = st.stepa_sync[1];
    assign sif_b.step_sync     = st.stepb_sync[1];
    assign sif_a.chip_active   = st.act_sync[1];
    assign sif_b.chip_active   = st.act_sync[1];
    assign sif_a.counter_reset = !st.ctrl_a[`DSS_CTRL_CNT_RESET_BIT];
    assign sif_b.counter_reset = !st.ctrl_b[`DSS_CTRL_CNT_RESET_BIT];
    assign sif_a.div_code      = st.div_mode[`DSS_DIV_A_LSB +: 2];
    assign sif_b.div_code      = st.div_mode[`DSS_DIV_B_LSB +: 2];
    assign sif_a.mode = dss_pkg::dss_mode_e'(st.div_mode[`DSS_MODE_A_LSB +: 2]);
    assign sif_b.mode = dss_pkg::dss_mode_e'(st.div_mode[`DSS_MODE_B_LSB +: 2]);

    always_comb begin
        next_st = st;
        next_st.act_sync   = {st.act_sync[0], chip_active_pin};
        next_st.stepa_sync = {st.stepa_sync[0], step_clock_pair_a};
        next_st.stepb_sync = {st.stepb_sync[0], step_clock_pair_b};

        // Writes are never gated by chip-active.
        if (cfg_write) begin
            case (cfg_addr)
                `DSS_REG_CTRL_A:   next_st.ctrl_a   = cfg_data;
                `DSS_REG_CTRL_B:   next_st.ctrl_b   = cfg_data;
                `DSS_REG_DIV_MODE: next_st.div_mode = cfg_data;
                `DSS_REG_CHOP_CFG: next_st.chop_cfg = cfg_data;
                default:           next_st.rdata    = st.rdata;
            endcase
        end
        case (cfg_addr)
            `DSS_REG_CTRL_A:   next_st.rdata = st.ctrl_a;
            `DSS_REG_CTRL_B:   next_st.rdata = st.ctrl_b;
            `DSS_REG_DIV_MODE: next_st.rdata = st.div_mode;
            `DSS_REG_CHOP_CFG: next_st.rdata = st.chop_cfg;
            default:           next_st.rdata = 8'h00;
        endcase

        // Chopping tick is a reference for the analog PWM; the period is rounded down.
        next_st.chop_tick = 1'b0;
        if (st.chop_cnt + 16'h1 >= dss_chop_period(st.chop_cfg[`DSS_CHOP_LSB +: 2])) begin
            next_st.chop_cnt  = 16'h0;
            next_st.chop_tick = 1'b1;
        end else begin
            next_st.chop_cnt = st.chop_cnt + 16'h1;
        end

        next_st.pos_a  = sif_a.position;
        next_st.pos_b  = sif_b.position;
        next_st.full_a = (sif_a.mode == dss_pkg::DSS_FULL);
        next_st.full_b = (sif_b.mode == dss_pkg::DSS_FULL);

        // Both the pin and pair A's enable bit must be on; pair A carries the global enable.
        next_st.out_en_n = !(st.act_sync[1] && st.ctrl_a[`DSS_CTRL_OUT_EN_BIT]);

        // The flag follows the position register, so it holds between step edges.
        if (st.chop_cfg[`DSS_FLAG_PAIR_BIT]) begin
            next_st.flag = !dss_flag_hit(st.chop_cfg[`DSS_FLAG_HALF_BIT], sif_b.mode,
                                         sif_b.at_initial, sif_b.at_half);
        end else begin
            next_st.flag = !dss_flag_hit(st.chop_cfg[`DSS_FLAG_HALF_BIT], sif_a.mode,
                                         sif_a.at_initial, sif_a.at_half);
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            st          <= '0;
            st.out_en_n <= 1'b1;
            st.flag     <= 1'b1;
            st.ctrl_a   <= `DSS_CTRL_RESET;
            st.ctrl_b   <= `DSS_CTRL_RESET;
        end else begin
            st <= next_st;
        end
    end

    dss_step_engine u_eng_a (
        .clk     (clk),
        .reset_n (reset_n),
        .sif     (sif_a)
    );

    dss_step_engine u_eng_b (
        .clk     (clk),
        .reset_n (reset_n),
        .sif     (sif_b)
    );

    assign cfg_rdata         = st.rdata;
    assign position_pair_a   = st.pos_a;
    assign position_pair_b   = st.pos_b;
    assign full_step_pair_a  = st.full_a;
    assign full_step_pair_b  = st.full_b;
    assign motor_out_en_n    = st.out_en_n;
    assign chop_tick         = st.chop_tick;
    assign sensor_drive      = st.chop_cfg[`DSS_SENSOR_BIT];
    assign position_flag_pin = st.flag;
endmodule
`default_nettype wire

//--- testbench/dss_sva.sv
// Concurrent checks on the step sequencer top ports.
`timescale 1ns/1ps
`default_nettype none
module dss_sva #(
    parameter int CLK_HZ = 50000000
) (
    input wire logic       clk,
    input wire logic       reset_n,
    input wire logic       chip_active_pin,
    input wire logic       step_clock_pair_a,
    input wire logic       step_clock_pair_b,
    input wire logic       cfg_write,
    input wire logic [7:0] cfg_addr,
    input wire logic [7:0] cfg_data,
    input wire logic [7:0] cfg_rdata,
    input wire logic [7:0] position_pair_a,
    input wire logic [7:0] position_pair_b,
    input wire logic       full_step_pair_a,
    input wire logic       full_step_pair_b,
    input wire logic       motor_out_en_n,
    input wire logic       chop_tick,
    input wire logic       sensor_drive,
    input wire logic       position_flag_pin
);
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    sequence wr_div_low;
        cfg_write && cfg_addr == 8'h02 && !chip_active_pin;
    endsequence
    sequence en_on;
        cfg_write && cfg_addr == 8'h00 && cfg_data[7];
    endsequence
    out_idle_a: assert property (!chip_active_pin [*4] |-> motor_out_en_n)
        else $error("outputs enabled while chip inactive");
    reset_val_a: assert property ($rose(reset_n) |-> motor_out_en_n && !sensor_drive)
        else $error("state not cleared by reset");
    pos_park_a: assert property (!chip_active_pin [*6] |->
        position_pair_a == (full_step_pair_a ? 8'hE0 : 8'h00)
        && position_pair_b == (full_step_pair_b ? 8'hE0 : 8'h00))
        else $error("position not parked");
    chop_pulse_a: assert property (chop_tick |=> !chop_tick)
        else $error("chop tick longer than one cycle");
    step_hold_a: assert property ((chip_active_pin && $stable(step_clock_pair_a)
        && !cfg_write) [*8] |-> $stable(position_pair_a)) else $error("step without edge");
    sensor_on_a: assert property (cfg_write && cfg_addr == 8'h03 && cfg_data[2]
        |=> sensor_drive) else $error("sensor drive not set");
    store_low_a: assert property (wr_div_low ##1 (!cfg_write && cfg_addr == 8'h02)
        |=> cfg_rdata == $past(cfg_data, 2)) else $error("write lost while inactive");
    out_on_a: assert property (en_on ##1 (chip_active_pin && !cfg_write) [*4]
        |=> !motor_out_en_n) else $error("outputs not enabled");
endmodule
bind dss_sequencer dss_sva #(.CLK_HZ(CLK_HZ)) dss_sva_i (.*);
`default_nettype wire

//--- testbench/dss_host.sv
// Host model that writes and reads the configuration bytes.
`timescale 1ns/1ps
`default_nettype none
module dss_host (
    input  wire logic       clk,
    input  wire logic [7:0] cfg_rdata,
    output logic            cfg_write,
    output logic [7:0]      cfg_addr,
    output logic [7:0]      cfg_data
);
    initial begin
        cfg_write = 1'b0;
        cfg_addr = 8'h00;
        cfg_data = 8'h00;
    end
    // The strobe stands for the 8th clock edge of the data byte.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        cfg_write = 1'b1;
        cfg_addr = a;
        cfg_data = d;
        @(negedge clk);
        cfg_write = 1'b0;
        cfg_data = ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk);
        cfg_addr = a;
        @(negedge clk);
        d = cfg_rdata;
    endtask
endmodule
`default_nettype wire

//--- testbench/tb.sv
// Self-checking bench for the step sequencer.
`timescale 1ns/1ps
`default_nettype none
module tb;
    localparam int CLK_HZ = 50000000;
    logic       clk = 1'b0;
    logic       reset_n = 1'b0;
    logic       chip_active_pin = 1'b0;
    logic       step_clock_pair_a = 1'b0;
    logic       step_clock_pair_b = 1'b0;
    logic       cfg_write, full_step_pair_a, full_step_pair_b, motor_out_en_n;
    logic       chop_tick, sensor_drive, position_flag_pin;
    logic [7:0] cfg_addr, cfg_data, cfg_rdata, position_pair_a, position_pair_b, rv;
    int         fails = 0;
    int         cmp_count = 0;
    always #10 clk = ~clk;
    dss_sequencer #(.CLK_HZ(CLK_HZ)) dss_sequencer_i (.*);
    dss_host dss_host_i (.*);
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // Pulses are held four cycles so the two-stage pin sync never misses one.
    task automatic pulse(input int n, input logic b);
        repeat (n) begin
            @(negedge clk);
            step_clock_pair_a = 1'b1;
            step_clock_pair_b = b;
            repeat (4) @(negedge clk);
            step_clock_pair_a = 1'b0;
            step_clock_pair_b = 1'b0;
            repeat (3) @(negedge clk);
        end
        repeat (4) @(negedge clk);
    endtask
    task automatic cres();
        dss_host_i.wr(8'h00, 8'h80);
        dss_host_i.wr(8'h00, 8'hC0);
    endtask
    task automatic t_regs();
        dss_host_i.wr(8'h05, 8'hFF);
        for (int i = 0; i < 6; i++) begin
            dss_host_i.rd(8'(i), rv);
            chk(rv, i < 2 ? 8'h40 : 8'h00);
        end
        chk(motor_out_en_n, 1'b1);
        chk(sensor_drive, 1'b0);
        chk(position_flag_pin, 1'b0);
    endtask
    task automatic t_div();
        for (int c = 0; c < 4; c++) begin
            cres();
            dss_host_i.wr(8'h02, 8'(c));
            pulse((1 << c) - 1, 1'b0);
            chk(position_pair_a, 8'h00);
            pulse(1, 1'b0);
            chk(position_pair_a, 8'h01);
        end
        chk(motor_out_en_n, 1'b0);
    endtask
    task automatic t_mode();
        for (int m = 0; m < 4; m++) begin
            cres();
            dss_host_i.wr(8'h02, 8'(m << 4));
            repeat (2) @(negedge clk);
            chk(position_pair_a, m == 3 ? 8'hE0 : 8'h00);
            pulse(1, 1'b0);
            chk(full_step_pair_a, m == 3);
            chk(position_pair_a, m == 0 ? 8'h01 : 8'h20);
        end
    endtask
    task automatic t_flag();
        cres();
        dss_host_i.wr(8'h02, 8'h00);
        dss_host_i.wr(8'h03, 8'h10);
        pulse(31, 1'b0);
        chk(position_flag_pin, 1'b1);
        pulse(1, 1'b0);
        chk(position_flag_pin, 1'b0);
        pulse(1, 1'b0);
        chk(position_flag_pin, 1'b1);
        dss_host_i.wr(8'h03, 8'h18);
        repeat (3) @(negedge clk);
        chk(position_flag_pin, 1'b0);
        dss_host_i.wr(8'h02, 8'h10);
        dss_host_i.wr(8'h03, 8'h10);
        cres();
        pulse(1, 1'b0);
        chk(position_flag_pin, 1'b1);
    endtask
    task automatic t_chip();
        pulse(1, 1'b1);
        chip_active_pin = 1'b0;
        dss_host_i.wr(8'h02, 8'h0F);
        dss_host_i.rd(8'h02, rv);
        chk(rv, 8'h0F);
        dss_host_i.wr(8'h03, 8'h04);
        chk(sensor_drive, 1'b1);
        pulse(2, 1'b1);
        chk(position_pair_a, 8'h00);
        chk(position_pair_b, 8'h00);
        chk(motor_out_en_n, 1'b1);
        chip_active_pin = 1'b1;
        pulse(8, 1'b1);
        chk(position_pair_b, 8'h01);
        chk(motor_out_en_n, 1'b0);
    endtask
    // Outputs off must not freeze the counters; pair B also runs full step here.
    task automatic t_oen();
        dss_host_i.wr(8'h00, 8'h40);
        dss_host_i.wr(8'h01, 8'h00);
        dss_host_i.wr(8'h01, 8'h40);
        dss_host_i.wr(8'h02, 8'hC0);
        repeat (2) @(negedge clk);
        chk(motor_out_en_n, 1'b1);
        chk(full_step_pair_b, 1'b1);
        chk(position_pair_b, 8'hE0);
        pulse(1, 1'b1);
        chk(position_pair_a, 8'h02);
        chk(position_pair_b, 8'h20);
        dss_host_i.wr(8'h00, 8'hC0);
        repeat (2) @(negedge clk);
        chk(motor_out_en_n, 1'b0);
        chk(position_pair_a, 8'h02);
    endtask
    task automatic t_chop();
        int f;
        int n;
        for (int c = 0; c < 4; c++) begin
            f = c == 0 ? 400000 : c == 1 ? 200000 : c == 2 ? 600000 : 300000;
            dss_host_i.wr(8'h03, 8'(c));
            repeat (2) begin
                n = 0;
                do begin
                    @(negedge clk);
                    n++;
                end while (chop_tick !== 1'b1 && n < 400);
            end
            chk(8'(n), 8'(CLK_HZ / f));
        end
    endtask
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    initial begin
        repeat (4) @(negedge clk);
        reset_n = 1'b1;
        chip_active_pin = 1'b1;
        t_regs();
        t_div();
        t_mode();
        t_flag();
        t_chip();
        t_oen();
        t_chop();
        wrap_up();
    end
    // The whole sequence needs about 2000 cycles; this allows fifteen times that.
    initial begin
        #600000;
        fails++;
        $display("[ERR] %0t timeout", $time);
        wrap_up();
    end
endmodule
`default_nettype wire
